/* verilog/acr_regs.v */
// register bank: conversion result and converter setup, pointer addressed
// assumes a bus front end on i_mclk that delivers whole bytes per frame
module acr_regs #(
  parameter HAS_MUX = 1,
  parameter HAS_PGA = 1
) (
  // clock and reset
  input wire i_mclk,
  input wire i_rst_n,
  // byte interface from the serial front end
  input wire i_wr_start,
  input wire i_gc_start,
  input wire i_wr_byte_vld,
  input wire [7:0] i_wr_byte,
  input wire i_rd_start,
  input wire i_rd_next,
  output wire [7:0] o_rd_byte,
  output wire o_rd_byte_vld,
  // converter core
  input wire i_conv_done,
  input wire [11:0] i_conv_data,
  output reg o_conv_start,
  output reg o_conv_run,
  output reg o_conv_busy,
  output reg [2:0] o_input_pair_select,
  output reg [2:0] o_full_scale_select,
  output reg [2:0] o_sample_rate_select
);
`include "acr_defs.vh"

  reg [7:0] register_pointer_byte_q;
  reg [11:0] result_q;
  reg [14:0] setup_q;
  reg [7:0] msb_q;
  reg [3:0] frame_q;
  reg [3:0] frame_d;
  reg gc_q;
  reg busy_q;
  reg start_or_idle_flag;
  reg [15:0] rd_word;
  reg [14:0] wr_setup;
  wire [15:0] wr_word;
  wire commit;
  wire soft_rst;
  wire frame_new;
  wire byte_take;

  // frame position, one-hot
  localparam [3:0] FR_PTR = 4'h1;
  localparam [3:0] FR_HI = 4'h2;
  localparam [3:0] FR_LO = 4'h4;
  localparam [3:0] FR_END = 4'h8;
  // reset image of the whole setup word, start bit included
  localparam [15:0] SETUP_RST = `ACR_SETUP_RST;

  // a frame start in the same cycle as a byte drops that byte
  assign frame_new = i_wr_start || i_gc_start;
  assign byte_take = i_wr_byte_vld && !frame_new;
  assign wr_word = {msb_q, i_wr_byte};
  assign commit = byte_take && !gc_q && (frame_q == FR_LO) &&
                  (register_pointer_byte_q == `ACR_PTR_SETUP);
  assign soft_rst = byte_take && gc_q && (frame_q == FR_PTR) &&
                    (i_wr_byte == `ACR_GC_RESET_CMD);

  // fixed fields on variants without the analog stage
  always @* begin
    wr_setup = wr_word[14:0];
    if (HAS_MUX == 0) begin
      wr_setup[`ACR_MUX_HI:`ACR_MUX_LO] = `ACR_MUX_FIXED;
    end
    if (HAS_PGA == 0) begin
      wr_setup[`ACR_FSR_HI:`ACR_FSR_LO] = `ACR_FSR_FIXED;
    end
  end

  // next frame position; bytes past the low byte are ignored
  always @* begin
    frame_d = frame_q;
    case (frame_q)
      FR_PTR: begin
        if (byte_take) begin
          frame_d = soft_rst ? FR_END : FR_HI;
        end
      end
      FR_HI: begin
        if (byte_take) begin
          frame_d = FR_LO;
        end
      end
      FR_LO: begin
        if (byte_take) begin
          frame_d = FR_END;
        end
      end
      FR_END: begin
        frame_d = FR_END;
      end
      default: begin
        frame_d = FR_END;
      end
    endcase
    if (frame_new) begin
      frame_d = FR_PTR;
    end
  end

  // frame position, pointer and high byte
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      register_pointer_byte_q <= `ACR_PTR_RESULT;
      msb_q <= 8'h00;
      frame_q <= FR_PTR;
      gc_q <= 1'b0;
    end else begin
      frame_q <= frame_d;
      if (frame_new) begin
        gc_q <= i_gc_start;
      end
      if (soft_rst) begin
        register_pointer_byte_q <= `ACR_PTR_RESULT;
      end
      if (byte_take && frame_q == FR_PTR && !gc_q) begin
        register_pointer_byte_q <= i_wr_byte;
      end
      if (byte_take && frame_q == FR_HI) begin
        msb_q <= i_wr_byte;
      end
    end
  end

  // setup register, conversion control and result
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      setup_q <= SETUP_RST[`ACR_MUX_HI:0];
      result_q <= `ACR_RESULT_RST;
      busy_q <= 1'b0;
      o_conv_start <= 1'b0;
    end else if (soft_rst) begin
      setup_q <= SETUP_RST[`ACR_MUX_HI:0];
      result_q <= `ACR_RESULT_RST;
      busy_q <= 1'b0;
      o_conv_start <= 1'b0;
    end else begin
      o_conv_start <= 1'b0;
      if (i_conv_done) begin
        result_q <= i_conv_data;
        busy_q <= 1'b0;
      end
      if (commit) begin
        setup_q <= wr_setup;
        // start only when idle and powered down
        if (wr_word[`ACR_BIT_START] && !busy_q &&
            setup_q[`ACR_BIT_MODE] && wr_setup[`ACR_BIT_MODE]) begin
          busy_q <= 1'b1;
          o_conv_start <= 1'b1;
        end
      end
    end
  end

  always @* begin
    start_or_idle_flag = setup_q[`ACR_BIT_MODE] & ~busy_q;
    if (register_pointer_byte_q == `ACR_PTR_RESULT) begin
      rd_word = {result_q, `ACR_RESULT_PAD};
    end else if (register_pointer_byte_q == `ACR_PTR_SETUP) begin
      rd_word = {start_or_idle_flag, setup_q};
    end else begin
      rd_word = 16'h0000;
    end
  end

  // registered field outputs
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_conv_run <= 1'b0;
      o_conv_busy <= 1'b0;
      o_input_pair_select <= SETUP_RST[`ACR_MUX_HI:`ACR_MUX_LO];
      o_full_scale_select <= SETUP_RST[`ACR_FSR_HI:`ACR_FSR_LO];
      o_sample_rate_select <= SETUP_RST[`ACR_RATE_HI:`ACR_RATE_LO];
    end else begin
      // continuous when mode bit is 0
      o_conv_run <= ~setup_q[`ACR_BIT_MODE];
      o_conv_busy <= busy_q;
      o_input_pair_select <= setup_q[`ACR_MUX_HI:`ACR_MUX_LO];
      o_full_scale_select <= setup_q[`ACR_FSR_HI:`ACR_FSR_LO];
      o_sample_rate_select <= setup_q[`ACR_RATE_HI:`ACR_RATE_LO];
    end
  end

  acr_byte_reader u_reader (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_load(i_rd_start),
    .i_word(rd_word),
    .i_next(i_rd_next),
    .o_byte(o_rd_byte),
    .o_valid(o_rd_byte_vld)
  );
endmodule

/* pkg/acr_defs.vh */
// constants of the converter setup and result register bank
// assumes the includer uses the bit positions as indices and the rest as sized literals
`ifndef ACR_DEFS_VH
`define ACR_DEFS_VH
`define ACR_PTR_RESULT 8'h00
`define ACR_PTR_SETUP 8'h01
`define ACR_RESULT_RST 12'h000
`define ACR_SETUP_RST 16'h8583
`define ACR_GC_RESET_CMD 8'h06
`define ACR_BIT_START 15
`define ACR_MUX_HI 14
`define ACR_MUX_LO 12
`define ACR_FSR_HI 11
`define ACR_FSR_LO 9
`define ACR_BIT_MODE 8
`define ACR_RATE_HI 7
`define ACR_RATE_LO 5
`define ACR_RSVD_HI 4
`define ACR_MUX_FIXED 3'h0
`define ACR_FSR_FIXED 3'h2
`define ACR_RESULT_PAD 4'h0
`endif

/* verilog/acr_byte_reader.v */
// sends a 16-bit register word one byte per request, high byte first
// assumes load and next requests come from logic on the same clock
module acr_byte_reader (
  // clock and reset
  input wire i_mclk,
  input wire i_rst_n,
  // word capture and byte requests
  input wire i_load,
  input wire [15:0] i_word,
  input wire i_next,
  // byte out
  output reg [7:0] o_byte,
  output reg o_valid
);
  reg [15:0] hold_q;
  reg sel_q;
  wire [15:0] word_w;
  wire sel_w;

  assign word_w = i_load ? i_word : hold_q;
  assign sel_w = i_load ? 1'b0 : sel_q;

  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hold_q <= 16'h0000;
      sel_q <= 1'b0;
      o_byte <= 8'h00;
      o_valid <= 1'b0;
    end else begin
      o_valid <= i_next;
      if (i_load) begin
        hold_q <= i_word;
      end
      if (i_next) begin
        o_byte <= sel_w ? word_w[7:0] : word_w[15:8];
        sel_q <= ~sel_w;
      end else if (i_load) begin
        sel_q <= 1'b0;
      end
    end
  end
endmodule

/* tb/acr_conv_model.sv */
// converter core stand-in: one result some cycles after each start
// assumes start is a one-cycle pulse on i_mclk
module acr_conv_model #(
  parameter LAT = 40
) (
  input wire i_mclk,
  input wire i_rst_n,
  input wire i_start,
  output reg o_done,
  output reg [11:0] o_data
);
  timeunit 1ns;
  timeprecision 1ns;
  integer c;
  // data churns outside the done cycle
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      c <= 0;
      o_done <= 1'b0;
      o_data <= 12'h000;
    end else begin
      o_done <= (c == 1);
      o_data <= (c == 1) ? 12'hABC : ~o_data;
      if (i_start) c <= LAT;
      else if (c > 0) c <= c - 1;
    end
  end
endmodule

/* tb/acr_regs_asserts.sv */
// port checks of the register bank
// assumes one clock and an async active-low reset
module acr_regs_asserts (
  input wire i_mclk,
  input wire i_rst_n,
  input wire i_gc_start,
  input wire i_wr_byte_vld,
  input wire [7:0] i_wr_byte,
  input wire i_rd_next,
  input wire i_conv_done,
  input wire o_rd_byte_vld,
  input wire o_conv_start,
  input wire o_conv_run,
  input wire o_conv_busy,
  input wire [2:0] o_sample_rate_select
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  start_sets_busy_a: assert property (o_conv_start |=> o_conv_busy)
    else $error("busy missing after start");
  start_pulse_a: assert property (o_conv_start |=> !o_conv_start)
    else $error("start longer than one cycle");
  no_restart_a: assert property (o_conv_start |-> !o_conv_busy)
    else $error("start while busy");
  done_idle_a: assert property (i_conv_done |=> ##1 !o_conv_busy)
    else $error("busy after done");
  run_no_start_a: assert property (o_conv_start |-> !o_conv_run)
    else $error("start in continuous mode");
  rd_answer_a: assert property (i_rd_next |=> o_rd_byte_vld)
    else $error("no byte after request");
  rd_cause_a: assert property (o_rd_byte_vld |-> $past(i_rd_next))
    else $error("byte without request");
  soft_reset_a: assert property (i_gc_start ##1
    (i_wr_byte_vld && i_wr_byte == 8'h06) |=> ##1
    (o_sample_rate_select == 3'h4 && !o_conv_busy && !o_conv_run))
    else $error("soft reset missed");
endmodule
bind acr_regs acr_regs_asserts u_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
  .i_gc_start(i_gc_start), .i_wr_byte_vld(i_wr_byte_vld),
  .i_wr_byte(i_wr_byte), .i_rd_next(i_rd_next), .i_conv_done(i_conv_done),
  .o_rd_byte_vld(o_rd_byte_vld), .o_conv_start(o_conv_start),
  .o_conv_run(o_conv_run), .o_conv_busy(o_conv_busy),
  .o_sample_rate_select(o_sample_rate_select));

/* tb/acr_regs_tb.sv */
// bench for the register bank, byte bus driven on falling edges
// assumes the converter stand-in answers every start
module acr_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  reg i_mclk = 0, i_rst_n = 0, i_wr_start = 0, i_gc_start = 0;
  reg i_wr_byte_vld = 0, i_rd_start = 0, i_rd_next = 0;
  reg [7:0] i_wr_byte = 0;
  wire [7:0] o_rd_byte;
  wire o_rd_byte_vld, o_conv_start, o_conv_run, o_conv_busy, done;
  wire [11:0] data;
  wire [2:0] ps, fs, rs, ps2, fs2;
  integer fail_count = 0, checks = 0, cyc = 0, i;
  always #50 i_mclk = ~i_mclk;
  acr_regs DUT (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_wr_start(i_wr_start),
    .i_gc_start(i_gc_start), .i_wr_byte_vld(i_wr_byte_vld),
    .i_wr_byte(i_wr_byte), .i_rd_start(i_rd_start), .i_rd_next(i_rd_next),
    .o_rd_byte(o_rd_byte), .o_rd_byte_vld(o_rd_byte_vld),
    .i_conv_done(done), .i_conv_data(data), .o_conv_start(o_conv_start),
    .o_conv_run(o_conv_run), .o_conv_busy(o_conv_busy),
    .o_input_pair_select(ps), .o_full_scale_select(fs),
    .o_sample_rate_select(rs));
  acr_conv_model u_conv (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_start(o_conv_start), .o_done(done), .o_data(data));
  // variant without input multiplexer and gain stage, same bus traffic
  acr_regs #(.HAS_MUX(0), .HAS_PGA(0)) u_fixed (.i_mclk(i_mclk),
    .i_rst_n(i_rst_n), .i_wr_start(i_wr_start), .i_gc_start(i_gc_start),
    .i_wr_byte_vld(i_wr_byte_vld), .i_wr_byte(i_wr_byte),
    .i_rd_start(i_rd_start), .i_rd_next(i_rd_next), .o_rd_byte(),
    .o_rd_byte_vld(), .i_conv_done(done), .i_conv_data(data),
    .o_conv_start(), .o_conv_run(), .o_conv_busy(),
    .o_input_pair_select(ps2), .o_full_scale_select(fs2),
    .o_sample_rate_select());
  task ck(input [15:0] g, input [15:0] e);
    begin
      checks = checks + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
    end
  endtask
  task wr(input g, input [23:0] w, input integer n);
    integer k;
    begin
      @(negedge i_mclk);
      i_wr_start = !g;
      i_gc_start = g;
      @(negedge i_mclk);
      i_wr_start = 0;
      i_gc_start = 0;
      for (k = 0; k < n; k = k + 1) begin
        i_wr_byte_vld = 1;
        i_wr_byte = w[23 - 8 * k -: 8];
        @(negedge i_mclk);
      end
      i_wr_byte_vld = 0;
      @(negedge i_mclk);
    end
  endtask
  task rd(input [15:0] e);
    begin
      @(negedge i_mclk);
      i_rd_start = 1;
      i_rd_next = 1;
      @(negedge i_mclk);
      i_rd_start = 0;
      ck({15'h0, o_rd_byte_vld}, 16'h1);
      ck({8'h0, o_rd_byte}, {8'h0, e[15:8]});
      @(negedge i_mclk);
      i_rd_next = 0;
      ck({8'h0, o_rd_byte}, {8'h0, e[7:0]});
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  always @(posedge i_mclk) begin
    cyc = cyc + 1;
    if (cyc > 3000) begin
      fail_count = fail_count + 1;
      give_verdict;
    end
  end
  initial begin
    repeat (5) @(negedge i_mclk);
    i_rst_n = 1;
    rd(16'h0000);
    wr(0, 24'h010000, 1);
    rd(16'h8583);
    $display("test reset done");
    wr(0, 24'h01C3E3, 3);
    ck({15'h0, o_conv_busy}, 16'h1);
    ck({10'h0, ps2, fs2}, 16'h0002);
    rd(16'h43E3);
    wr(0, 24'h01C3E3, 3);
    ck({7'h0, ps, fs, rs}, 16'h010F);
    for (i = 0; i < 100 && o_conv_busy !== 1'b0; i = i + 1) @(negedge i_mclk);
    rd(16'hC3E3);
    wr(0, 24'h000000, 1);
    rd(16'hABC0);
    $display("test single done");
    wr(0, 24'h010483, 3);
    ck({15'h0, o_conv_run}, 16'h1);
    rd(16'h0483);
    wr(1, 24'h060000, 1);
    rd(16'h0000);
    wr(0, 24'h010000, 1);
    rd(16'h8583);
    $display("test modes done");
    give_verdict;
  end
endmodule
